// >>> hw/nfs_pkg.sv
// constants of the serial flash feature and status bit bank
package nfs_pkg;
   localparam int ADDR_W = 8;
   // ----------------------------------------
   // feature addresses
   // ----------------------------------------
   localparam logic [7:0] ADR_PROT = 8'hA0;
   localparam logic [7:0] ADR_FEAT = 8'hB0;
   localparam logic [7:0] ADR_STAT = 8'hC0;
   localparam logic [7:0] ADR_DRV = 8'hD0;
   localparam logic [7:0] ADR_STAT2 = 8'hF0;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int PR_GATE = 7;
   localparam int FE_OTP_LOCK = 7;
   localparam int FE_OTP_ACC = 6;
   localparam int FE_ECC = 4;
   localparam int FE_FRZ = 3;
   localparam int FE_QUAD = 0;
   localparam int DR_DS = 5;
   // ----------------------------------------
   // reset values and writable masks
   // ----------------------------------------
   localparam logic [7:0] PROT_RST = 8'h38;
   localparam logic [7:0] FEAT_RST = 8'h10;
   localparam logic [7:0] DRV_RST = 8'h00;
   localparam logic [7:0] PROT_MASK = 8'hBE;
   localparam logic [7:0] FEAT_MASK = 8'hD9;
   localparam logic [7:0] DRV_MASK = 8'h60;
   // ----------------------------------------
   // commands
   // ----------------------------------------
   localparam logic [7:0] CMD_WREN = 8'h06;
   localparam logic [7:0] CMD_WRDI = 8'h04;
   localparam logic [7:0] CMD_READ = 8'h13;
   localparam logic [7:0] CMD_PROG = 8'h10;
   localparam logic [7:0] CMD_ERASE = 8'hD8;
   localparam logic [7:0] CMD_SRST = 8'hFF;
   localparam logic [7:0] CMD_ARM = 8'h66;
   localparam logic [7:0] CMD_POR = 8'h99;
   // ----------------------------------------
   // operation kinds and timing
   // ----------------------------------------
   localparam logic [1:0] KIND_BOOT = 2'h0;
   localparam logic [1:0] KIND_READ = 2'h1;
   localparam logic [1:0] KIND_PROG = 2'h2;
   localparam logic [1:0] KIND_ERASE = 2'h3;
   localparam int CLK_NS = 100;
   localparam int SOFT_RST_NS = 1000;
   localparam int POR_NS = 1000;
   localparam int SOFT_CYC = (SOFT_RST_NS + CLK_NS - 1) / CLK_NS;
   localparam int POR_CYC = (POR_NS + CLK_NS - 1) / CLK_NS;
   localparam int FRAME_BITS = 8;
   typedef enum logic [2:0] {S_IDLE, S_READ, S_PROG, S_ERASE, S_RST} nfs_state_t;
endpackage

// >>> hw/nfs_bank.sv
// feature, protection and status bit bank with apb access and command events
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/100ps
module nfs_bank
   import nfs_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RSTN_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [ADDR_W-1:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic SCK_I,
   input wire logic CS_N_I,
   input wire logic WP_N_I,
   input wire logic CMD_VALID_I,
   input wire logic [7:0] CMD_CODE_I,
   input wire logic TARGET_LOCKED_I,
   input wire logic OP_DONE_I,
   input wire logic OP_FAIL_I,
   input wire logic [3:0] ECC_RES_I,
   output logic OP_START_O,
   output logic [1:0] OP_KIND_O,
   output logic OP_ABORT_O,
   output logic BUSY_O,
   output logic ECC_ON_O,
   output logic QUAD_ALLOW_O,
   output logic OTP_ACCESS_O,
   output logic OTP_LOCK_O,
   output logic [1:0] DRIVE_SEL_O
);
   // ----------------------------------------
   // pin synchronisers and frame tracking
   // ----------------------------------------
   logic [2:0] pin_s1, pin_s2;
   logic sck_d, cs_d, pend_v, next_pend_v;
   logic [3:0] edge_cnt, next_edge_cnt;
   logic [7:0] pend_code, next_pend_code;
   logic sck_rise, cs_rise, cmd_fire, wp_low;

   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         pin_s1 <= 3'h7;
         pin_s2 <= 3'h7;
         sck_d <= 1'b1;
         cs_d <= 1'b1;
      end else begin
         pin_s1 <= {WP_N_I, CS_N_I, SCK_I};
         pin_s2 <= pin_s1;
         sck_d <= pin_s2[0];
         cs_d <= pin_s2[1];
      end
   end

   assign sck_rise = pin_s2[0] && !sck_d;
   assign cs_rise = pin_s2[1] && !cs_d;
   assign wp_low = !pin_s2[2];
   assign cmd_fire = cs_rise && pend_v && (edge_cnt == 4'(FRAME_BITS));

   always_comb begin
      next_edge_cnt = edge_cnt;
      next_pend_v = pend_v;
      next_pend_code = pend_code;
      if (pin_s2[1]) begin
         next_edge_cnt = 4'h0;
      end else if (sck_rise && edge_cnt != 4'(FRAME_BITS)) begin
         next_edge_cnt = edge_cnt + 4'h1;
      end
      if (CMD_VALID_I) begin
         next_pend_v = 1'b1;
         next_pend_code = CMD_CODE_I;
      end else if (cs_rise) begin
         next_pend_v = 1'b0;
      end
   end

   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         edge_cnt <= 4'h0;
         pend_v <= 1'b0;
         pend_code <= 8'h00;
      end else begin
         edge_cnt <= next_edge_cnt;
         pend_v <= next_pend_v;
         pend_code <= next_pend_code;
      end
   end

   // ----------------------------------------
   // operation sequencer and status flags
   // ----------------------------------------
   nfs_state_t st, next_st;
   logic [7:0] rst_cnt, next_rst_cnt;
   logic boot, next_boot, arm, next_arm;
   logic [3:0] ecc, next_ecc;
   logic pfail, next_pfail, efail, next_efail, write_permit_latch, next_wel, selected_block_locked;
   logic next_start, next_abort, por_fire, soft_fire;
   logic [1:0] next_kind;

   assign soft_fire = cmd_fire && pend_code == CMD_SRST;
   assign por_fire = cmd_fire && pend_code == CMD_POR && arm;

   always_comb begin
      next_st = st;
      next_rst_cnt = rst_cnt;
      next_boot = boot;
      next_arm = arm;
      next_ecc = ecc;
      next_pfail = pfail;
      next_efail = efail;
      next_wel = write_permit_latch;
      next_start = 1'b0;
      next_kind = OP_KIND_O;
      next_abort = 1'b0;
      if (cmd_fire) begin
         next_arm = 1'b0;
      end
      if (soft_fire || por_fire) begin
         next_abort = 1'b1;
         next_st = S_RST;
         next_rst_cnt = por_fire ? 8'(POR_CYC) : 8'(SOFT_CYC);
         next_boot = por_fire;
         next_ecc = 4'h0;
         next_pfail = 1'b0;
         next_efail = 1'b0;
         next_wel = 1'b0;
      end else if (cmd_fire && st == S_IDLE) begin
         unique case (pend_code)
            CMD_WREN: next_wel = 1'b1;
            CMD_WRDI: next_wel = 1'b0;
            CMD_ARM: next_arm = 1'b1;
            CMD_READ: begin
               next_ecc = 4'h0;
               next_st = S_READ;
               next_start = 1'b1;
               next_kind = KIND_READ;
            end
            CMD_PROG: begin
               next_pfail = 1'b0;
               if (write_permit_latch) begin
                  next_wel = 1'b0;
                  if (TARGET_LOCKED_I) begin
                     next_pfail = 1'b1;
                  end else begin
                     next_st = S_PROG;
                     next_start = 1'b1;
                     next_kind = KIND_PROG;
                  end
               end
            end
            CMD_ERASE: begin
               next_efail = 1'b0;
               if (write_permit_latch) begin
                  next_wel = 1'b0;
                  if (TARGET_LOCKED_I) begin
                     next_efail = 1'b1;
                  end else begin
                     next_st = S_ERASE;
                     next_start = 1'b1;
                     next_kind = KIND_ERASE;
                  end
               end
            end
            default: begin
            end
         endcase
      end else begin
         unique case (st)
            S_IDLE: begin
            end
            S_READ: begin
               if (OP_DONE_I) begin
                  next_ecc = ECC_RES_I;
                  next_st = S_IDLE;
               end
            end
            S_PROG: begin
               if (OP_DONE_I) begin
                  next_pfail = pfail || OP_FAIL_I;
                  next_st = S_IDLE;
               end
            end
            S_ERASE: begin
               if (OP_DONE_I) begin
                  next_efail = efail || OP_FAIL_I;
                  next_st = S_IDLE;
               end
            end
            S_RST: begin
               next_rst_cnt = rst_cnt - 8'h01;
               if (rst_cnt <= 8'h01) begin
                  next_st = boot ? S_READ : S_IDLE;
                  next_start = boot;
                  next_kind = KIND_BOOT;
                  next_boot = 1'b0;
               end
            end
         endcase
      end
   end

   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         st <= S_RST;
         rst_cnt <= 8'(POR_CYC);
         boot <= 1'b1;
         arm <= 1'b0;
         ecc <= 4'h0;
         pfail <= 1'b0;
         efail <= 1'b0;
         write_permit_latch <= 1'b0;
         selected_block_locked <= 1'b1;
         BUSY_O <= 1'b1;
         OP_START_O <= 1'b0;
         OP_KIND_O <= KIND_BOOT;
         OP_ABORT_O <= 1'b0;
      end else begin
         st <= next_st;
         rst_cnt <= next_rst_cnt;
         boot <= next_boot;
         arm <= next_arm;
         ecc <= next_ecc;
         pfail <= next_pfail;
         efail <= next_efail;
         write_permit_latch <= next_wel;
         selected_block_locked <= TARGET_LOCKED_I;
         BUSY_O <= next_st != S_IDLE;
         OP_START_O <= next_start;
         OP_KIND_O <= next_kind;
         OP_ABORT_O <= next_abort;
      end
   end

   // ----------------------------------------
   // feature bytes and apb slave
   // ----------------------------------------
   logic [7:0] prot;
   logic [7:0] next_prot;
   logic [7:0] feat;
   logic [7:0] next_feat;
   logic [7:0] drv;
   logic [7:0] next_drv;
   logic [31:0] next_rdata;
   logic next_ready;
   logic next_err;
   logic wr_commit;
   logic setup;
   logic prot_locked;

   assign setup = PSEL_I && !PENABLE_I;
   assign wr_commit = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
   assign prot_locked = feat[FE_FRZ] || (prot[PR_GATE] && wp_low);

   always_comb begin
      next_prot = prot;
      next_feat = feat;
      next_drv = drv;
      next_ready = setup;
      next_err = 1'b0;
      next_rdata = 32'h0000_0000;
      if (setup) begin
         unique case (PADDR_I)
            ADR_PROT: next_rdata = {24'h00_0000, prot};
            ADR_FEAT: next_rdata = {24'h00_0000, feat};
            ADR_STAT: next_rdata = {26'h000_0000, ecc[3:2], pfail, efail, write_permit_latch, BUSY_O};
            ADR_DRV: next_rdata = {24'h00_0000, drv};
            ADR_STAT2: next_rdata = {26'h000_0000, ecc[1:0], selected_block_locked, 3'h0};
            default: next_err = 1'b1;
         endcase
      end
      if (por_fire) begin
         next_prot = PROT_RST;
         next_feat = FEAT_RST;
         next_drv = DRV_RST;
      end else if (wr_commit) begin
         if (PADDR_I == ADR_PROT && !prot_locked) begin
            next_prot = PWDATA_I[7:0] & PROT_MASK;
         end
         if (PADDR_I == ADR_FEAT) begin
            next_feat = PWDATA_I[7:0] & FEAT_MASK;
            next_feat[FE_FRZ] = feat[FE_FRZ] || PWDATA_I[FE_FRZ];
         end
         if (PADDR_I == ADR_DRV) begin
            next_drv = PWDATA_I[7:0] & DRV_MASK;
         end
      end
   end

   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         prot <= PROT_RST;
         feat <= FEAT_RST;
         drv <= DRV_RST;
         PRDATA_O <= 32'h0000_0000;
         PREADY_O <= 1'b0;
         PSLVERR_O <= 1'b0;
         ECC_ON_O <= FEAT_RST[FE_ECC];
         QUAD_ALLOW_O <= FEAT_RST[FE_QUAD];
         OTP_ACCESS_O <= FEAT_RST[FE_OTP_ACC];
         OTP_LOCK_O <= FEAT_RST[FE_OTP_LOCK];
         DRIVE_SEL_O <= DRV_RST[DR_DS+1:DR_DS];
      end else begin
         prot <= next_prot;
         feat <= next_feat;
         drv <= next_drv;
         PRDATA_O <= next_rdata;
         PREADY_O <= next_ready;
         PSLVERR_O <= next_err;
         ECC_ON_O <= next_feat[FE_ECC];
         QUAD_ALLOW_O <= next_feat[FE_QUAD];
         OTP_ACCESS_O <= next_feat[FE_OTP_ACC];
         OTP_LOCK_O <= next_feat[FE_OTP_LOCK];
         DRIVE_SEL_O <= next_drv[DR_DS+1:DR_DS];
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   localparam int BOOT_WAIT = POR_CYC + 2;

   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!RSTN_I);

   chk_gate_blocks: assert property (
      wr_commit && PADDR_I == ADR_PROT && prot[PR_GATE] && wp_low && !por_fire
      |=> prot == $past(prot))
      else $error("protection byte changed while gated");
   chk_freeze_holds: assert property (
      feat[FE_FRZ] && !por_fire |=> feat[FE_FRZ] && prot == $past(prot))
      else $error("frozen protection changed");
   chk_soft_keeps: assert property (
      soft_fire && !wr_commit |=> prot == $past(prot) && drv == $past(drv)
      && feat == $past(feat))
      else $error("soft reset altered feature bytes");
   chk_read_clears: assert property (
      cmd_fire && pend_code == CMD_READ && st == S_IDLE |=> ecc == 4'h0 && BUSY_O)
      else $error("page read did not clear ecc fields");
   chk_ecc_load: assert property (
      st == S_READ && OP_DONE_I && !cmd_fire |=> ecc == $past(ECC_RES_I) && !BUSY_O)
      else $error("ecc fields not loaded at read end");
   chk_boot_read: assert property (
      por_fire |-> ##[1:BOOT_WAIT] (OP_START_O && OP_KIND_O == KIND_BOOT))
      else $error("no boot read after power-on reset");
   chk_prog_locked: assert property (
      cmd_fire && pend_code == CMD_PROG && st == S_IDLE && write_permit_latch && TARGET_LOCKED_I
      |=> pfail && !BUSY_O && !OP_START_O)
      else $error("locked program did not fail");
   chk_erase_locked: assert property (
      cmd_fire && pend_code == CMD_ERASE && st == S_IDLE && write_permit_latch && TARGET_LOCKED_I
      |=> efail && !BUSY_O)
      else $error("locked erase did not fail");
   chk_wel_reset: assert property (
      soft_fire |=> !write_permit_latch ##1 (BUSY_O && st == S_RST))
      else $error("latch survived soft reset");
   chk_start_busy: assert property (
      OP_START_O |-> BUSY_O && st != S_IDLE)
      else $error("operation started while ready");

   cov_boot: cover property (por_fire ##[1:BOOT_WAIT] OP_START_O);
   cov_prog_done: cover property (st == S_PROG && OP_DONE_I && OP_FAIL_I);
   cov_abort_read: cover property (st == S_READ && soft_fire);
   cov_frozen_write: cover property (wr_commit && PADDR_I == ADR_PROT && prot_locked);
endmodule

// >>> verif/nfs_host_model.sv
// serial host and array model on the far side of the feature bit bank
`timescale 1ns/100ps
module nfs_host_model
   import nfs_pkg::*;
(
   input wire logic clk_i,
   input wire logic op_start_i,
   input wire logic [1:0] op_kind_i,
   input wire logic op_abort_i,
   output logic sck_o,
   output logic cs_n_o,
   output logic cmd_valid_o,
   output logic [7:0] cmd_code_o,
   output logic op_done_o,
   output logic op_fail_o,
   output logic [3:0] ecc_res_o
);
   logic fail_next = 1'b0;
   logic [3:0] ecc_next = 4'h0;
   logic [1:0] kind = 2'h3;
   int wait_cyc = 3;
   int cnt = 0;
   int aborts = 0;
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      cmd_valid_o = 1'b0;
      cmd_code_o = 8'h00;
      op_done_o = 1'b0;
      op_fail_o = 1'b0;
      ecc_res_o = 4'h0;
   end
   // ----------------------------------------
   // one command frame, link clock idle low outside it
   // ----------------------------------------
   task automatic send(input logic [7:0] code);
      @(posedge clk_i);
      cs_n_o <= 1'b0;
      cmd_valid_o <= 1'b1;
      cmd_code_o <= code;
      @(posedge clk_i);
      cmd_valid_o <= 1'b0;
      cmd_code_o <= ~code;
      #37;
      repeat (16) begin
         #400;
         sck_o = ~sck_o;
      end
      repeat (2) @(posedge clk_i);
      cs_n_o <= 1'b1;
      repeat (8) @(posedge clk_i);
   endtask
   // ----------------------------------------
   // array answers each started operation unless an abort arrives before the answer
   // ----------------------------------------
   always @(posedge clk_i) begin
      op_done_o <= 1'b0;
      op_fail_o <= ~op_fail_o;
      ecc_res_o <= ~ecc_res_o;
      if (op_abort_i === 1'b1) begin
         cnt <= 0;
         aborts <= aborts + 1;
      end else if (op_start_i === 1'b1) begin
         kind <= op_kind_i;
         cnt <= wait_cyc;
      end else if (cnt == 1) begin
         op_done_o <= 1'b1;
         op_fail_o <= fail_next;
         ecc_res_o <= ecc_next;
         cnt <= 0;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end
   end
endmodule

// >>> verif/nfs_bank_test.sv
// self-checking bench for the feature and status bit bank
`timescale 1ns/100ps
module nfs_bank_test;
   import nfs_pkg::*;
   typedef struct packed {logic rd; logic err; logic [31:0] d;} nfs_note_t;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, b, d;
   logic [31:0] pwdata = 32'h0000_0000, prdata;
   logic pready, pslverr, sck, cs_n, cvalid, done, fail, start, abort, busy;
   logic ecc_on, quad, otp_acc, otp_lock, wp_n = 1'b1, tlock = 1'b1;
   logic [7:0] code;
   logic [3:0] ecc;
   logic [1:0] kind, drv;
   nfs_note_t notes[$];
   nfs_note_t note;
   integer seed;
   int miscompares = 0, tests_run = 0;
   always #50 clk = ~clk;
   nfs_bank u_dut (.CLK_I(clk), .RSTN_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
      .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .SCK_I(sck), .CS_N_I(cs_n), .WP_N_I(wp_n),
      .CMD_VALID_I(cvalid), .CMD_CODE_I(code), .TARGET_LOCKED_I(tlock), .OP_DONE_I(done),
      .OP_FAIL_I(fail), .ECC_RES_I(ecc), .OP_START_O(start), .OP_KIND_O(kind),
      .OP_ABORT_O(abort), .BUSY_O(busy), .ECC_ON_O(ecc_on), .QUAD_ALLOW_O(quad),
      .OTP_ACCESS_O(otp_acc), .OTP_LOCK_O(otp_lock), .DRIVE_SEL_O(drv));
   nfs_host_model u_host (.clk_i(clk), .op_start_i(start), .op_kind_i(kind),
      .op_abort_i(abort), .sck_o(sck), .cs_n_o(cs_n), .cmd_valid_o(cvalid),
      .cmd_code_o(code), .op_done_o(done), .op_fail_o(fail), .ecc_res_o(ecc));
   // ----------------------------------------
   // compare, bus master and result monitor
   // ----------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] wd,
      input logic [7:0] e, input logic err);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'($random(seed)), wd};
      notes.push_back('{~w, err, {24'h00_0000, e}});
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) miscompares++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00, e, 1'b0);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      apb(1'b1, a, v, 8'h00, 1'b0);
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 400) begin
         @(posedge clk);
         n++;
      end
      if (n >= 400) miscompares++;
   endtask
   always @(posedge clk) begin
      if (pready === 1'b1) begin
         note = notes.pop_front();
         check("pslverr", {31'h0, pslverr}, {31'h0, note.err});
         if (note.rd) check("prdata", prdata, note.d);
      end
   end
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      #2_000_000;
      miscompares++;
      summarize();
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      seed = 32'hcd76ce22;
      u_host.ecc_next = 4'b1010;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      rd(ADR_PROT, 8'h38);
      rd(ADR_FEAT, 8'h10);
      rd(ADR_DRV, 8'h00);
      rd(ADR_STAT, 8'h01);
      rd(ADR_STAT2, 8'h08);
      apb(1'b0, 8'h10, 8'h00, 8'h00, 1'b1);
      wr(ADR_STAT, 8'hFF);
      wait_idle();
      rd(ADR_STAT, 8'h20);
      rd(ADR_STAT2, 8'h28);
      check("kind", {30'h0, u_host.kind}, {30'h0, KIND_BOOT});
      $display("test power_up done");
      for (int i = 0; i < 4; i++) begin
         b = 8'($random(seed)) & FEAT_MASK & 8'hF7;
         wr(ADR_FEAT, b);
         rd(ADR_FEAT, b);
         check("ecc_on", {31'h0, ecc_on}, {31'h0, b[FE_ECC]});
         check("quad", {31'h0, quad}, {31'h0, b[FE_QUAD]});
         check("otp", {30'h0, otp_lock, otp_acc}, {30'h0, b[7:6]});
         d = 8'($random(seed)) & DRV_MASK;
         wr(ADR_DRV, d);
         rd(ADR_DRV, d);
         check("drive", {30'h0, drv}, {30'h0, d[6:5]});
      end
      wr(ADR_FEAT, 8'h10);
      wr(ADR_PROT, 8'h80);
      wp_n <= 1'b0;
      repeat (3) @(posedge clk);
      wr(ADR_PROT, 8'h3C);
      rd(ADR_PROT, 8'h80);
      wp_n <= 1'b1;
      repeat (3) @(posedge clk);
      wr(ADR_PROT, 8'h3C);
      rd(ADR_PROT, 8'h3C);
      $display("test features done");
      u_host.send(CMD_WREN);
      rd(ADR_STAT, 8'h22);
      u_host.send(CMD_WRDI);
      rd(ADR_STAT, 8'h20);
      u_host.send(CMD_WREN);
      u_host.send(CMD_PROG);
      rd(ADR_STAT, 8'h28);
      tlock <= 1'b0;
      u_host.wait_cyc = 40;
      u_host.send(CMD_WREN);
      u_host.send(CMD_PROG);
      rd(ADR_STAT, 8'h21);
      check("kind", {30'h0, u_host.kind}, {30'h0, KIND_PROG});
      wait_idle();
      rd(ADR_STAT, 8'h20);
      tlock <= 1'b1;
      u_host.send(CMD_WREN);
      u_host.send(CMD_ERASE);
      rd(ADR_STAT, 8'h24);
      tlock <= 1'b0;
      u_host.fail_next = 1'b1;
      u_host.send(CMD_WREN);
      u_host.send(CMD_ERASE);
      rd(ADR_STAT, 8'h21);
      check("kind", {30'h0, u_host.kind}, {30'h0, KIND_ERASE});
      wait_idle();
      rd(ADR_STAT, 8'h24);
      u_host.fail_next = 1'b0;
      u_host.ecc_next = 4'b0111;
      u_host.send(CMD_READ);
      rd(ADR_STAT, 8'h05);
      wait_idle();
      rd(ADR_STAT, 8'h14);
      rd(ADR_STAT2, 8'h30);
      check("kind", {30'h0, u_host.kind}, {30'h0, KIND_READ});
      $display("test operations done");
      u_host.wait_cyc = 300;
      u_host.send(CMD_READ);
      u_host.send(CMD_SRST);
      wait_idle();
      check("aborts", u_host.aborts, 32'h0000_0001);
      rd(ADR_STAT, 8'h00);
      rd(ADR_STAT2, 8'h00);
      rd(ADR_FEAT, 8'h10);
      rd(ADR_PROT, 8'h3C);
      rd(ADR_DRV, d);
      u_host.wait_cyc = 40;
      wr(ADR_FEAT, 8'h18);
      wr(ADR_PROT, 8'hBE);
      rd(ADR_PROT, 8'h3C);
      wr(ADR_FEAT, 8'h10);
      rd(ADR_FEAT, 8'h18);
      u_host.send(CMD_SRST);
      wait_idle();
      rd(ADR_FEAT, 8'h18);
      $display("test soft_reset done");
      u_host.send(CMD_POR);
      rd(ADR_PROT, 8'h3C);
      u_host.ecc_next = 4'b1101;
      u_host.send(CMD_ARM);
      u_host.send(CMD_POR);
      wait_idle();
      rd(ADR_PROT, 8'h38);
      rd(ADR_FEAT, 8'h10);
      rd(ADR_DRV, 8'h00);
      rd(ADR_STAT, 8'h30);
      rd(ADR_STAT2, 8'h10);
      $display("test power_on_reset done");
      summarize();
   end
endmodule
